// file: logic/twb_pkg.sv
// Purpose: shared constants and types of the two-wire protocol engine
// Assumes: one 50 MHz clock, quarter-bit timing from a divider
// Notes: status codes are read with the prescaler bits as zero
package twb_pkg;
    // ========================================================
    // engine states
    typedef enum logic [2:0] {
        ST_IDLE,  // bus released, not master
        ST_HOLD,  // master, clock held low, waiting for host
        ST_LOAD,  // waiting for a transmit byte from the fifo
        ST_START, // start or repeated start condition
        ST_BIT,   // one bit of a nine-bit packet
        ST_STOP   // stop condition
    } eng_state_t;
    // ========================================================
    // control word fields
    localparam int CTL_W = 4;
    localparam int CTL_ACK = 0;   // answer received bytes with ack
    localparam int CTL_STOP = 1;  // send stop
    localparam int CTL_START = 2; // send start
    localparam int CTL_CLEAR = 3; // write one clears the done flag
    // ========================================================
    // widths and counts
    localparam int BYTE_W = 8;
    localparam int DIV_W = 8;
    localparam int ADDR_W = 7;
    localparam int TX_FIFO_DEPTH = 4;
    localparam logic [3:0] ACK_IDX = 4'h8;     // ninth bit
    localparam logic [1:0] PH_LAST = 2'h3;     // last bit phase
    localparam logic [1:0] STOP_LAST = 2'h2;   // last stop phase
    localparam logic [8:0] Q_EXTRA = 9'h003;   // quarter = div + 4
    // ========================================================
    // status codes
    localparam logic [7:0] STS_START = 8'h08;
    localparam logic [7:0] STS_RSTART = 8'h10;
    localparam logic [7:0] STS_AW_ACK = 8'h18;
    localparam logic [7:0] STS_AW_NACK = 8'h20;
    localparam logic [7:0] STS_DW_ACK = 8'h28;
    localparam logic [7:0] STS_DW_NACK = 8'h30;
    localparam logic [7:0] STS_ARB_LOST = 8'h38;
    localparam logic [7:0] STS_AR_ACK = 8'h40;
    localparam logic [7:0] STS_AR_NACK = 8'h48;
    localparam logic [7:0] STS_DR_ACK = 8'h50;
    localparam logic [7:0] STS_DR_NACK = 8'h58;
    localparam logic [7:0] STS_NONE = 8'hF8;
endpackage : twb_pkg

// file: logic/twb_fifo.sv
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: in_ready is registered; data words are not reset
`timescale 1ns/1ps
module twb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // ========================================================
    // storage and pointers
    logic [WIDTH-1:0] mem [DEPTH]; // word storage
    logic [AW-1:0] wr_r;           // write pointer
    logic [AW-1:0] rd_r;           // read pointer
    logic [AW:0] cnt_r;            // words held
    logic [AW:0] cnt_nxt;          // words held next cycle
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_r];
    assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // ========================================================
    // word write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    // pointers, count and registered ready
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            // full stalls the source
            in_ready <= (cnt_nxt != (AW + 1)'(DEPTH));
        end
    end
endmodule : twb_fifo

// file: logic/two_wire_bus_protocol_engine.sv
// Purpose: master engine of a two-wire bus with arbitration
// Assumes: pins are wired-AND; oe high pulls the line low
// Notes: after a lost arbitration the engine clocks out the packet undriven, flags a match of its own address, then idles
`timescale 1ns/1ps
module two_wire_bus_protocol_engine import twb_pkg::*; #(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [DIV_W-1:0] bit_rate_divider,
    input wire logic [ADDR_W-1:0] own_address,
    input wire logic ctl_wr,
    input wire logic [CTL_W-1:0] bus_control_register,
    input wire logic tx_valid,
    input wire logic [BYTE_W-1:0] tx_data,
    output logic tx_ready,
    output logic done,
    output logic [BYTE_W-1:0] bus_status_register,
    output logic [BYTE_W-1:0] rx_data,
    output logic addressed,
    output logic arb_lost
);
    // ========================================================
    // declarations
    eng_state_t state_r;            // engine state
    logic [1:0] phase_r;            // quarter phase of a step
    logic [3:0] bit_cnt_r;          // bit of the packet, 0..8
    logic [BYTE_W-1:0] shift_r;     // bus byte shift register
    logic [8:0] q_cnt_r;            // quarter counter
    logic [1:0] scl_sync_r;         // clock pin synchroniser
    logic [1:0] sda_sync_r;         // data pin synchroniser
    logic first_r;                  // packet is the address
    logic rx_mode_r;                // data packets are received
    logic ack_en_r;                 // ack the byte being received
    logic ack_rx_r;                 // ack seen from the receiver
    logic lost_r;                   // arbitration lost
    logic rep_r;                    // next start is a repeat
    logic pend_r;                   // start queued behind stop
    logic done_r;                   // operation complete flag
    logic [BYTE_W-1:0] status_r;    // status code
    logic [BYTE_W-1:0] rx_data_r;   // last byte seen on the bus
    logic addressed_r;              // own address seen after loss
    logic scl_oe_r;                 // clock pull-down
    logic sda_oe_r;                 // data pull-down
    logic scl_s;                    // synchronised clock level
    logic sda_s;                    // synchronised data level
    logic stall;                    // wait for a line to rise
    logic run;                      // quarter counter runs
    logic tick;                     // end of a quarter
    logic bit_step;                 // advance a bit phase
    logic go;                       // host starts an action
    logic tx_mode;                  // this packet is sent by us
    logic drv_low;                  // data level wanted, low
    logic byte_end;                 // ninth bit finishes
    logic fifo_valid;
    logic [BYTE_W-1:0] fifo_data;
    logic fifo_pop;

    // ========================================================
    // transmit byte buffer
    twb_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready(tx_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    // ========================================================
    // pin synchronisers, first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
        end
    end

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];

    // ========================================================
    // step control
    // a released line that stays low holds the phase
    assign stall = (state_r == ST_BIT && phase_r == 2'h2 && !scl_s)
        || (state_r == ST_START && phase_r == 2'h1
            && !(scl_s && sda_s))
        || (state_r == ST_STOP && phase_r == 2'h1 && !scl_s);
    assign run = (state_r == ST_START || state_r == ST_BIT
        || state_r == ST_STOP) && !stall;
    assign tick = run && (q_cnt_r == 9'h000);
    // another master pulling the clock ends our high early
    assign bit_step = tick || (state_r == ST_BIT
        && phase_r == PH_LAST && !scl_s);
    assign go = ctl_wr && bus_control_register[CTL_CLEAR]
        && (state_r == ST_IDLE || state_r == ST_HOLD);
    assign tx_mode = first_r || !rx_mode_r;
    // bits 0..7 from the sender, bit 8 from the receiver
    assign drv_low = !lost_r && ((bit_cnt_r < ACK_IDX)
        ? (tx_mode && !shift_r[7])
        : (!tx_mode && ack_en_r));
    assign byte_end = state_r == ST_BIT && bit_step
        && phase_r == PH_LAST && bit_cnt_r == ACK_IDX;
    assign fifo_pop = (state_r == ST_LOAD);

    // ========================================================
    // quarter-bit divider, reloads with divider plus margin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_cnt_r <= Q_EXTRA;
        end else if (!run || tick) begin
            // held while stretched, so high time is ours
            q_cnt_r <= {1'b0, bit_rate_divider} + Q_EXTRA;
        end else begin
            q_cnt_r <= q_cnt_r - 9'h001;
        end
    end

    // ========================================================
    // sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            phase_r <= 2'h0;
            bit_cnt_r <= 4'h0;
            first_r <= 1'b0;
            rx_mode_r <= 1'b0;
            rep_r <= 1'b0;
            pend_r <= 1'b0;
            ack_en_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // only a start leaves idle
                    if (go && bus_control_register[CTL_START]) begin
                        state_r <= ST_START;
                        phase_r <= 2'h0;
                    end
                end
                ST_HOLD: begin
                    if (go) begin
                        phase_r <= 2'h0;
                        bit_cnt_r <= 4'h0;
                        ack_en_r <= bus_control_register[CTL_ACK];
                        if (bus_control_register[CTL_STOP]) begin
                            state_r <= ST_STOP;
                            pend_r <= bus_control_register[CTL_START];
                        end else if (bus_control_register[CTL_START]) begin
                            state_r <= ST_START;
                        end else if (tx_mode) begin
                            state_r <= ST_LOAD;
                        end else begin
                            state_r <= ST_BIT;
                        end
                    end
                end
                ST_LOAD: begin
                    // clock stays low until a byte is there
                    if (fifo_valid) begin
                        state_r <= ST_BIT;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        if (phase_r == PH_LAST) begin
                            state_r <= ST_HOLD;
                            first_r <= 1'b1;
                            rep_r <= 1'b1;
                        end else begin
                            phase_r <= phase_r + 2'h1;
                        end
                    end
                end
                ST_BIT: begin
                    if (bit_step) begin
                        if (phase_r != PH_LAST) begin
                            phase_r <= phase_r + 2'h1;
                        end else if (bit_cnt_r != ACK_IDX) begin
                            phase_r <= 2'h0;
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else begin
                            // packet done; a loser lets the bus go
                            state_r <= lost_r ? ST_IDLE : ST_HOLD;
                            phase_r <= 2'h0;
                            first_r <= 1'b0;
                            if (lost_r) begin
                                rep_r <= 1'b0;
                            end
                            if (first_r) begin
                                rx_mode_r <= shift_r[0];
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        if (phase_r == STOP_LAST) begin
                            state_r <= pend_r ? ST_START : ST_IDLE;
                            phase_r <= 2'h0;
                            rep_r <= 1'b0;
                            pend_r <= 1'b0;
                        end else begin
                            phase_r <= phase_r + 2'h1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // shift register, ack capture and arbitration watch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= 8'h00;
            ack_rx_r <= 1'b0;
            lost_r <= 1'b0;
        end else begin
            if (fifo_pop && fifo_valid) begin
                shift_r <= fifo_data;
            end else if (state_r == ST_BIT && tick
                && phase_r == 2'h2) begin
                if (bit_cnt_r < ACK_IDX) begin
                    // bus byte shifted in whoever sends it
                    shift_r <= {shift_r[6:0], sda_s};
                    if (tx_mode && !sda_oe_r && !sda_s) begin
                        lost_r <= 1'b1;
                    end
                end else begin
                    ack_rx_r <= !sda_s;
                    if (!tx_mode && !sda_oe_r && !sda_s) begin
                        lost_r <= 1'b1;
                    end
                end
            end else if (go && bus_control_register[CTL_START]) begin
                lost_r <= 1'b0;
            end
        end
    end

    // ========================================================
    // done flag, status and received byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            status_r <= STS_NONE;
            rx_data_r <= 8'h00;
            addressed_r <= 1'b0;
        end else begin
            // a set wins over a clear in the same cycle
            if (state_r == ST_START && tick && phase_r == PH_LAST) begin
                done_r <= 1'b1;
                status_r <= rep_r ? STS_RSTART : STS_START;
            end else if (byte_end) begin
                done_r <= 1'b1;
                rx_data_r <= shift_r;
                if (lost_r) begin
                    status_r <= STS_ARB_LOST;
                    addressed_r <= first_r
                        && (shift_r[7:1] == own_address);
                end else if (first_r) begin
                    status_r <= shift_r[0]
                        ? (ack_rx_r ? STS_AR_ACK : STS_AR_NACK)
                        : (ack_rx_r ? STS_AW_ACK : STS_AW_NACK);
                end else if (tx_mode) begin
                    status_r <= ack_rx_r ? STS_DW_ACK : STS_DW_NACK;
                end else begin
                    status_r <= ack_en_r ? STS_DR_ACK : STS_DR_NACK;
                end
            end else if (go) begin
                done_r <= 1'b0;
                addressed_r <= 1'b0;
            end else if (state_r == ST_STOP && tick
                && phase_r == STOP_LAST) begin
                status_r <= STS_NONE;
            end
        end
    end

    // ========================================================
    // line drive, one cycle behind the sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    scl_oe_r <= 1'b0;
                    sda_oe_r <= 1'b0;
                end
                ST_HOLD, ST_LOAD: begin
                    scl_oe_r <= 1'b1; // host time, clock kept low
                end
                ST_START: begin
                    // release data, release clock, data low
                    sda_oe_r <= (phase_r >= 2'h2);
                    if (phase_r != 2'h0) begin
                        scl_oe_r <= 1'b0;
                    end
                end
                ST_BIT: begin
                    // low half driven, high half released
                    scl_oe_r <= (phase_r < 2'h2);
                    if (phase_r == 2'h0) begin
                        sda_oe_r <= drv_low;
                    end
                end
                ST_STOP: begin
                    // data low, clock up, then data up
                    scl_oe_r <= (phase_r == 2'h0);
                    sda_oe_r <= (phase_r != STOP_LAST);
                end
                default: begin
                    scl_oe_r <= 1'b0;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign done = done_r;
    assign bus_status_register = status_r;
    assign rx_data = rx_data_r;
    assign addressed = addressed_r;
    assign arb_lost = lost_r;

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // start completes, flag set, then clock held
    sequence s_held;
        (state_r == ST_HOLD && done_r) ##1 scl_oe_r;
    endsequence

    sequence s_start_end;
        state_r == ST_START && tick && phase_r == PH_LAST;
    endsequence

    AST_NINE_BITS: assert property (
        state_r == ST_BIT |-> bit_cnt_r <= ACK_IDX)
        else $error("bit count past ninth bit");
    AST_ACK_LOW: assert property (
        (state_r == ST_BIT && phase_r == 2'h1 && bit_cnt_r == ACK_IDX
         && !tx_mode && ack_en_r && !lost_r) |-> sda_oe_r)
        else $error("ack not driven low");
    AST_NACK_HIGH: assert property (
        (state_r == ST_BIT && phase_r == 2'h1 && bit_cnt_r == ACK_IDX
         && !tx_mode && !ack_en_r) |-> !sda_oe_r)
        else $error("not-ack drove data low");
    AST_MSB_FIRST: assert property (
        (state_r == ST_BIT && phase_r == 2'h1 && bit_cnt_r < ACK_IDX
         && tx_mode && !lost_r) |-> sda_oe_r == !shift_r[7])
        else $error("data bit not msb of shift");
    AST_STRETCH_WAIT: assert property (
        (state_r == ST_BIT && phase_r == 2'h2 && !scl_s)
        |=> state_r == ST_BIT && phase_r == 2'h2)
        else $error("phase moved while clock held low");
    AST_HIGH_RELEASED: assert property (
        (state_r == ST_BIT && phase_r == PH_LAST) |-> !scl_oe_r)
        else $error("clock pulled during high phase");
    AST_ARB_DETECT: assert property (
        (state_r == ST_BIT && tick && phase_r == 2'h2
         && bit_cnt_r < ACK_IDX && tx_mode && !sda_oe_r && !sda_s)
        |=> lost_r)
        else $error("mismatch not flagged as lost");
    AST_LOST_RELEASE: assert property (
        lost_r |-> !sda_oe_r)
        else $error("data driven after loss");
    AST_LOST_CODE: assert property (
        (byte_end && lost_r) |=> status_r == STS_ARB_LOST
        && state_r == ST_IDLE && done_r)
        else $error("lost packet end wrong");
    AST_START_CODE: assert property (
        s_start_end |=> s_held and
        (status_r == STS_START || status_r == STS_RSTART))
        else $error("start end wrong status or hold");
    AST_GO_CLEARS: assert property (
        (go && state_r == ST_HOLD) |=> !done_r && state_r != ST_HOLD)
        else $error("go did not clear flag and act");
endmodule : two_wire_bus_protocol_engine

// file: sim/twb_slave.sv
// Purpose: behavioural slave on the shared two-wire bus
// Assumes: lines are wired-AND with pull-ups
// Notes: acks writes, sends DOUT on reads; optional stretch after a byte
`timescale 1ns/1ps
module twb_slave #(parameter logic [6:0] ADDR = 7'h50,
    parameter logic [7:0] DOUT = 8'h96) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic scl_pull = 1'b0,
    output logic sda_pull = 1'b0,
    output logic [7:0] last_byte = 8'h00
);
    logic scl_q = 1'b1, sda_q = 1'b1, first = 1'b0, mine = 1'b0, rd = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] sh = 8'h00;
    int hold = 0;
    // ========================================
    // bit counter, shifter, ack and stretch
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda) begin // start seen
            cnt <= 4'h0;
            first <= 1'b1;
            rd <= 1'b0;
        end else if (scl && !scl_q) begin
            if (cnt < 4'h8) sh <= {sh[6:0], sda};
            else if (sda) rd <= 1'b0; // not-ack ends a read
            cnt <= cnt + 4'h1;
        end else if (!scl && scl_q) begin
            if (cnt == 4'h8) begin
                last_byte <= sh;
                first <= 1'b0;
                mine <= first ? (sh[7:1] == ADDR) : mine;
                rd <= first ? (sh[7:1] == ADDR) && sh[0] : rd;
                sda_pull <= first ? (sh[7:1] == ADDR) : mine && !rd;
                hold <= stretch ? 40 : 0;
            end else if (cnt == 4'h9) begin
                sda_pull <= rd && !DOUT[7];
                cnt <= 4'h0;
            end else if (rd) sda_pull <= !DOUT[4'h7 - cnt];
        end else if (hold > 0) hold <= hold - 1;
        scl_pull <= hold > 0;
    end
endmodule : twb_slave

// file: sim/two_wire_bus_protocol_engine_test.sv
// Purpose: self-checking bench of the protocol engine
// Assumes: one slave model at address 0x50, bench can jam data low
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module two_wire_bus_protocol_engine_test;
    import twb_pkg::*;
    logic clk = 0, rst_b = 0, ctl_wr = 0, tx_valid = 0, jam = 0, st = 0;
    logic [3:0] word = 4'h0;
    logic [6:0] own = 7'h11;
    logic [7:0] txd = 8'h00, sts, rxd, lb;
    logic c_oe, d_oe, c_o, d_o, tx_ready, done, addressed, arb_lost, pc, pd;
    wire scl = !(c_oe | pc);
    wire sda = !(d_oe | pd | jam);
    int n_fail = 0, tests_run = 0, cyc = 0;
    always #10 clk = !clk;
    two_wire_bus_protocol_engine i_two_wire_bus_protocol_engine (.clk(clk),
        .rst_b(rst_b), .scl_i(scl), .scl_o(c_o), .scl_oe(c_oe), .sda_i(sda),
        .sda_o(d_o), .sda_oe(d_oe), .bit_rate_divider(8'h01),
        .own_address(own), .ctl_wr(ctl_wr), .bus_control_register(word),
        .tx_valid(tx_valid), .tx_data(txd), .tx_ready(tx_ready), .done(done),
        .bus_status_register(sts), .rx_data(rxd), .addressed(addressed),
        .arb_lost(arb_lost));
    twb_slave i_twb_slave (.clk(clk), .scl(scl), .sda(sda), .stretch(st),
        .scl_pull(pc), .sda_pull(pd), .last_byte(lb));
    task automatic end_sim();
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic go(input logic [3:0] w); // a stop alone gives no done
        @(negedge clk) {ctl_wr, word} = {1'b1, w};
        @(negedge clk) ctl_wr = 0;
        chk("clear", 8'h00, {7'h0, done});
        if (w[CTL_START] || !w[CTL_STOP]) begin
            for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
            chk("done", 8'h01, {7'h0, done});
        end
    endtask : go
    task automatic push(input logic [7:0] b);
        @(negedge clk) {tx_valid, txd} = {1'b1, b};
        @(negedge clk) tx_valid = 0;
    endtask : push
    task automatic t_write(); // fills fifo, stretched transfer
        logic [7:0] b[4] = '{8'hA0, 8'h5A, 8'hC3, 8'h0F};
        logic [7:0] s[4] = '{8'h18, 8'h28, 8'h28, 8'h28};
        st = 1;
        go(4'hC);
        chk("status", 8'h08, sts);
        foreach (b[i]) push(b[i]);
        chk("ready", 8'h00, {7'h0, tx_ready});
        foreach (b[i]) begin
            go(4'h8);
            chk("status", s[i], sts);
            chk("byte", b[i], lb);
        end
        chk("ready", 8'h01, {7'h0, tx_ready});
        go(4'hA);
        repeat (60) @(negedge clk);
        chk("idle", 8'hF8, sts);
    endtask : t_write
    task automatic t_nack(); // unknown address refused, then a repeat
        st = 0;
        go(4'hC);
        push(8'h22);
        go(4'h8);
        chk("status", 8'h20, sts);
        go(4'hC);
        chk("status", 8'h10, sts);
        push(8'h22);
        go(4'h8);
        chk("status", 8'h20, sts);
        go(4'hA);
        repeat (60) @(negedge clk);
    endtask : t_nack
    task automatic t_read(); // two bytes read, ack then not-ack
        go(4'hC);
        push(8'hA1);
        go(4'h8);
        chk("status", 8'h40, sts);
        go(4'h9);
        chk("status", 8'h50, sts);
        chk("rx", 8'h96, rxd);
        go(4'h8);
        chk("status", 8'h58, sts);
        chk("rx", 8'h96, rxd);
        go(4'hE);
        chk("status", 8'h08, sts);
        push(8'hA0);
        go(4'h8);
        chk("status", 8'h18, sts);
        go(4'hA);
        repeat (60) @(negedge clk);
        chk("idle", 8'hF8, sts);
    endtask : t_read
    task automatic t_arb(input logic [6:0] a, input logic [7:0] hit);
        own = a;
        go(4'hC);
        jam = 1; // rival holds data low in the address
        push(8'hFE);
        go(4'h8);
        chk("status", 8'h38, sts);
        chk("lost", 8'h01, {7'h0, arb_lost});
        chk("addr", hit, {7'h0, addressed});
        chk("sda", 8'h00, {7'h0, d_oe});
        chk("pins", 8'h00, {6'h0, c_o, d_o});
        jam = 0;
    endtask : t_arb
    always @(posedge clk) begin // hang guard
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rst_b = 1;
        t_write();
        t_nack();
        t_read();
        t_arb(7'h11, 8'h00);
        t_arb(7'h00, 8'h01);
        end_sim();
    end
endmodule : two_wire_bus_protocol_engine_test
